// [xor_dir_pkg.sv]
// package: opcode selects, operand widths, addresses and reset values for the xor/direction block
package xor_dir_pkg;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned FADDR_W     = 5;
  localparam logic [2:0]  DIR_ADDR_A  = 3'h6;
  localparam logic [2:0]  DIR_ADDR_B  = 3'h7;
  localparam logic [7:0]  W_RESET     = 8'h00;
  localparam logic [7:0]  DIR_RESET   = 8'hff;
  localparam logic        ZERO_RESET  = 1'b0;
  localparam logic        DEST_W      = 1'b0;
  localparam logic        DEST_F      = 1'b1;

  typedef enum logic [1:0] {
    OP_NONE     = 2'b00,
    OP_DIR_LOAD = 2'b01,
    OP_XOR_REG  = 2'b10,
    OP_XOR_LIT  = 2'b11
  } op_sel_t;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_FETCH_F  = 2'b01,
    ST_WRITE    = 2'b10
  } exec_state_t;
endpackage

// [xor_unit.sv]
// combinational xor and zero detect shared by both xor operations
`timescale 1ns/1ns
module xor_unit #(
  parameter int unsigned WIDTH = 8
) (
  // operands
  input  wire logic [WIDTH-1:0] a,
  input  wire logic [WIDTH-1:0] b,
  // result
  output logic      [WIDTH-1:0] y,
  output logic                  is_zero
);
  always_comb begin
    y       = a ^ b;
    is_zero = ~|(a ^ b);
  end
endmodule

// [xor_and_direction_load_ops.sv]
// execution datapath for direction load, register xor and literal xor
// Behaviour
// - direction load copies working register into direction register 6 or 7; no flags.
// - register xor combines working register with file register 0..31; only zero flag.
// - destination bit 0 writes working register; 1 writes back the file register.
// - literal xor combines working register with 8-bit literal into working register.
`timescale 1ns/1ns
module xor_and_direction_load_ops #(
  parameter int unsigned WIDTH = xor_dir_pkg::DATA_W,
  parameter int unsigned AW    = xor_dir_pkg::FADDR_W
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  // decoded instruction
  input  wire logic             op_valid,
  input  wire logic [1:0]       op_sel,
  input  wire logic [AW-1:0]    op_faddr,
  input  wire logic             op_dest,
  input  wire logic [WIDTH-1:0] op_literal,
  // file register port
  output logic                  f_rd_en,
  output logic      [AW-1:0]    f_addr,
  input  wire logic [WIDTH-1:0] f_rd_data,
  output logic                  f_wr_en,
  output logic      [WIDTH-1:0] f_wr_data,
  // core state
  output logic      [WIDTH-1:0] working,
  output logic                  zero_flag,
  output logic      [WIDTH-1:0] dir_port_a,
  output logic      [WIDTH-1:0] dir_port_b,
  output logic                  busy,
  output logic                  done
);
  xor_dir_pkg::exec_state_t state, next_state;
  // decode of the op taken this cycle
  logic             take;
  logic             take_dir_load;
  logic             take_xor_reg;
  logic             take_xor_lit;
  logic             dir_hit_a;
  logic             dir_hit_b;
  // sequencing
  logic             next_busy;
  logic             next_done;
  logic             dest_hold;
  logic             next_dest_hold;
  // file port
  logic             next_f_rd_en;
  logic             next_f_wr_en;
  logic [AW-1:0]    next_f_addr;
  logic [WIDTH-1:0] next_f_wr_data;
  // working, flag and direction registers
  logic [WIDTH-1:0] next_working;
  logic             next_zero_flag;
  logic [WIDTH-1:0] next_dir_port_a;
  logic [WIDTH-1:0] next_dir_port_b;
  // shared xor
  logic [WIDTH-1:0] xor_b;
  logic [WIDTH-1:0] xor_y;
  logic             xor_zero;

  // literal in idle, file data once fetched
  assign xor_b = (state == xor_dir_pkg::ST_WRITE) ? f_rd_data : op_literal;

  xor_unit #(.WIDTH(WIDTH)) u_xor (
    .a       (working),
    .b       (xor_b),
    .y       (xor_y),
    .is_zero (xor_zero)
  );

  // op decode; ops are only taken while idle
  always_comb begin
    take          = op_valid && (state == xor_dir_pkg::ST_IDLE);
    take_dir_load = 1'b0;
    take_xor_reg  = 1'b0;
    take_xor_lit  = 1'b0;
    dir_hit_a     = (op_faddr[2:0] == xor_dir_pkg::DIR_ADDR_A);
    dir_hit_b     = (op_faddr[2:0] == xor_dir_pkg::DIR_ADDR_B);
    if (take) begin
      unique case (xor_dir_pkg::op_sel_t'(op_sel))
        xor_dir_pkg::OP_DIR_LOAD: begin
          take_dir_load = 1'b1;
        end
        xor_dir_pkg::OP_XOR_REG: begin
          take_xor_reg = 1'b1;
        end
        xor_dir_pkg::OP_XOR_LIT: begin
          take_xor_lit = 1'b1;
        end
        xor_dir_pkg::OP_NONE: begin
          take_xor_lit = 1'b0;
        end
      endcase
    end
  end

  // sequencing: a register xor reads, waits for the file data, then writes
  always_comb begin
    next_state     = state;
    next_busy      = 1'b0;
    next_done      = 1'b0;
    next_dest_hold = dest_hold;
    unique case (state)
      xor_dir_pkg::ST_IDLE: begin
        if (take_xor_reg) begin
          next_state     = xor_dir_pkg::ST_FETCH_F;
          next_busy      = 1'b1;
          next_dest_hold = op_dest;
        end else if (take_dir_load || take_xor_lit) begin
          // single-cycle ops finish at once
          next_done = 1'b1;
        end
      end
      xor_dir_pkg::ST_FETCH_F: begin
        next_state = xor_dir_pkg::ST_WRITE;
        next_busy  = 1'b1;
      end
      xor_dir_pkg::ST_WRITE: begin
        next_state = xor_dir_pkg::ST_IDLE;
        next_done  = 1'b1;
      end
      default: begin
        next_state = xor_dir_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state     <= xor_dir_pkg::ST_IDLE;
      busy      <= 1'b0;
      done      <= 1'b0;
      dest_hold <= xor_dir_pkg::DEST_W;
    end else begin
      state     <= next_state;
      busy      <= next_busy;
      done      <= next_done;
      dest_hold <= next_dest_hold;
    end
  end

  // file port: read strobe on a register xor take, write strobe registered from the write state
  always_comb begin
    next_f_rd_en   = 1'b0;
    next_f_addr    = f_addr;
    next_f_wr_en   = 1'b0;
    next_f_wr_data = f_wr_data;
    if (take_xor_reg) begin
      next_f_rd_en = 1'b1;
      next_f_addr  = op_faddr;
    end
    if ((state == xor_dir_pkg::ST_WRITE) && (dest_hold == xor_dir_pkg::DEST_F)) begin
      next_f_wr_en   = 1'b1;
      next_f_wr_data = xor_y;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      f_rd_en   <= 1'b0;
      f_wr_en   <= 1'b0;
      f_addr    <= '0;
      f_wr_data <= '0;
    end else begin
      f_rd_en   <= next_f_rd_en;
      f_wr_en   <= next_f_wr_en;
      f_addr    <= next_f_addr;
      f_wr_data <= next_f_wr_data;
    end
  end

  // working register and zero flag; direction loads leave both alone
  always_comb begin
    next_working   = working;
    next_zero_flag = zero_flag;
    if (take_xor_lit) begin
      next_working   = xor_y;
      next_zero_flag = xor_zero;
    end else if (state == xor_dir_pkg::ST_WRITE) begin
      if (dest_hold == xor_dir_pkg::DEST_W) begin
        next_working = xor_y;
      end
      next_zero_flag = xor_zero;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      working   <= xor_dir_pkg::W_RESET;
      zero_flag <= xor_dir_pkg::ZERO_RESET;
    end else begin
      working   <= next_working;
      zero_flag <= next_zero_flag;
    end
  end

  // direction registers; addresses whose low three bits are not 6 or 7 only pulse done
  always_comb begin
    next_dir_port_a = dir_port_a;
    next_dir_port_b = dir_port_b;
    if (take_dir_load && dir_hit_a) begin
      next_dir_port_a = working;
    end
    if (take_dir_load && dir_hit_b) begin
      next_dir_port_b = working;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dir_port_a <= xor_dir_pkg::DIR_RESET;
      dir_port_b <= xor_dir_pkg::DIR_RESET;
    end else begin
      dir_port_a <= next_dir_port_a;
      dir_port_b <= next_dir_port_b;
    end
  end
endmodule

// [xor_dir_sva.sv]
// port assertions for the xor and direction load block
`timescale 1ns/1ns
module xor_dir_sva (
  input logic       clk_sys, arst_n, op_valid, op_dest,
  input logic       busy, done, f_rd_en, f_wr_en, zero_flag,
  input logic [1:0] op_sel,
  input logic [4:0] op_faddr, f_addr,
  input logic [7:0] op_literal, f_rd_data, f_wr_data, working, dir_port_a, dir_port_b
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire take = op_valid && !busy;
  AST_DIR_LOAD: assert property (take && op_sel == 2'h1 && op_faddr[2:0] == 3'h6 |=>
    done && dir_port_a == $past(working) && $stable(zero_flag)) else $error("dir load");
  AST_FETCH: assert property (take && op_sel == 2'h2 |=> f_rd_en && busy &&
    f_addr == $past(op_faddr) ##1 busy && !f_rd_en ##1 done && !busy) else $error("fetch");
  AST_XOR_W: assert property (take && op_sel == 2'h2 && !op_dest |-> ##3 !f_wr_en &&
    working == ($past(f_rd_data) ^ $past(working))) else $error("xor to working");
  AST_XOR_F: assert property (take && op_sel == 2'h2 && op_dest |-> ##3 f_wr_en &&
    f_wr_data == ($past(f_rd_data) ^ working)) else $error("xor to file");
  AST_XOR_LIT: assert property (take && op_sel == 2'h3 |=> done &&
    working == ($past(working) ^ $past(op_literal))) else $error("literal xor");
  AST_ZERO: assert property (f_wr_en |-> zero_flag == (f_wr_data == 8'h00))
    else $error("zero flag");
  AST_DIR_LOAD_B: assert property (take && op_sel == 2'h1 && op_faddr[2:0] == 3'h7 |=>
    done && dir_port_b == $past(working) && $stable(dir_port_a)) else $error("dir load b");
  AST_DIR_OTHER: assert property (take && op_sel == 2'h1 && op_faddr[2:1] != 2'h3 |=>
    done && $stable(dir_port_a) && $stable(dir_port_b)) else $error("dir load other");
  AST_ZERO_LIT: assert property (take && op_sel == 2'h3 |=>
    zero_flag == (working == 8'h00)) else $error("literal zero");
  AST_ZERO_W: assert property (take && op_sel == 2'h2 && !op_dest |-> ##3
    zero_flag == (working == 8'h00)) else $error("xor zero to working");
endmodule

// [xor_and_direction_load_ops_tb.sv]
// self-checking bench for the xor and direction load block
`timescale 1ns/1ns
module xor_and_direction_load_ops_tb;
  logic       clk_sys = 0, arst_n = 0, op_valid = 0, op_dest = 0;
  logic [1:0] op_sel = 2'h0;
  logic [4:0] op_faddr = 5'h00, f_addr;
  logic [7:0] op_literal = 8'h00, f_rd_data = 8'h00;
  logic       f_rd_en, f_wr_en, zero_flag, busy, done;
  logic [7:0] f_wr_data, working, dir_port_a, dir_port_b;
  logic [7:0] mem [32];
  int         failures = 0, check_count = 0;
  xor_and_direction_load_ops u_xor_and_direction_load_ops (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .op_valid   (op_valid),
    .op_sel     (op_sel),
    .op_faddr   (op_faddr),
    .op_dest    (op_dest),
    .op_literal (op_literal),
    .f_rd_en    (f_rd_en),
    .f_addr     (f_addr),
    .f_rd_data  (f_rd_data),
    .f_wr_en    (f_wr_en),
    .f_wr_data  (f_wr_data),
    .working    (working),
    .zero_flag  (zero_flag),
    .dir_port_a (dir_port_a),
    .dir_port_b (dir_port_b),
    .busy       (busy),
    .done       (done)
  );
  initial forever #5 clk_sys = ~clk_sys;
  initial foreach (mem[i]) mem[i] = 8'(i * 8'h1d);
  // file side: data valid while busy (fetch and write states), a moving pattern otherwise
  always @(negedge clk_sys) begin
    if (f_wr_en) mem[f_addr] <= f_wr_data;
    f_rd_data <= busy ? mem[f_addr] : f_rd_data ^ 8'h5a;
  end
  task automatic check(input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic run_op(input logic [1:0] s, input logic [4:0] a, input logic d,
                        input logic [7:0] k);
    int n;
    // one edge between ops so op_valid never moves twice in a time step
    @(negedge clk_sys);
    op_valid = 1;
    op_sel = s;
    op_faddr = a;
    op_dest = d;
    op_literal = k;
    @(negedge clk_sys);
    op_valid = 0;
    for (n = 0; n < 5 && done !== 1'b1; n++) @(negedge clk_sys);
    if (n == 5) begin
      failures++;
      $display("ERROR %0t: no completion pulse", $time);
      end_of_test();
    end
  endtask
  task automatic sc_reset;
    arst_n = 0;
    repeat (12) @(negedge clk_sys);
    arst_n = 1;
    check(dir_port_a & dir_port_b, 8'hff);
    check(working, 8'h00);
    check(zero_flag, 1'b0);
  endtask
  // literal ops back to back, the last one giving zero
  task automatic sc_literal;
    logic [7:0] k [3] = '{8'h3c, 8'hff, 8'hc3};
    logic [7:0] e [3] = '{8'h3c, 8'hc3, 8'h00};
    for (int i = 0; i < 3; i++) begin
      run_op(2'h3, 5'h00, 1'b0, k[i]);
      check(working, e[i]);
      check(zero_flag, e[i] == 8'h00);
    end
  endtask
  // no-op code after the literal run: nothing moves, no completion pulse
  task automatic sc_none;
    @(negedge clk_sys);
    op_valid = 1;
    op_sel = 2'h0;
    op_literal = 8'hff;
    @(negedge clk_sys);
    op_valid = 0;
    check(done, 1'b0);
    check(working, 8'h00);
    check(zero_flag, 1'b1);
  endtask
  task automatic sc_dir;
    run_op(2'h1, 5'h06, 1'b0, 8'h00);
    check(dir_port_a, 8'h00);
    check(zero_flag, 1'b1);
    run_op(2'h3, 5'h00, 1'b0, 8'ha5);
    run_op(2'h1, 5'h07, 1'b0, 8'h00);
    check(dir_port_b, 8'ha5);
    run_op(2'h1, 5'h05, 1'b0, 8'h00);
    check(dir_port_a ^ dir_port_b, 8'ha5);
  endtask
  task automatic sc_reg;
    logic [7:0] e;
    e = 8'ha5 ^ mem[31];
    run_op(2'h2, 5'h1f, 1'b0, 8'h00);
    check(working, e);
    check(f_wr_en, 1'b0);
    run_op(2'h2, 5'h00, 1'b1, 8'h00);
    check(f_wr_data, e);
    run_op(2'h2, 5'h00, 1'b1, 8'h00);
    check(f_wr_data, 8'h00);
    check(zero_flag, 1'b1);
    check(working, e);
  endtask
  initial begin
    sc_reset();
    sc_literal();
    sc_none();
    sc_dir();
    sc_reg();
    sc_reset();
    end_of_test();
  end
endmodule
bind xor_and_direction_load_ops xor_dir_sva u_xor_dir_sva (
  .clk_sys    (clk_sys),
  .arst_n     (arst_n),
  .op_valid   (op_valid),
  .op_dest    (op_dest),
  .busy       (busy),
  .done       (done),
  .f_rd_en    (f_rd_en),
  .f_wr_en    (f_wr_en),
  .zero_flag  (zero_flag),
  .op_sel     (op_sel),
  .op_faddr   (op_faddr),
  .f_addr     (f_addr),
  .op_literal (op_literal),
  .f_rd_data  (f_rd_data),
  .f_wr_data  (f_wr_data),
  .working    (working),
  .dir_port_a (dir_port_a),
  .dir_port_b (dir_port_b)
);
